// ---- rtl/mon_pkg.sv ----
// ============================================================================
// Purpose: Shared constants and types for the monitor round-robin sequencer.
// Assumes: 250 MHz core clock and a 22.5 kHz converter timebase.
// Notes:   Every offset, field position, limit and config reset value and timing count is here.
// ============================================================================
package mon_pkg;

    // ========================================================================
    // Channel map.
    // ========================================================================
    localparam int NUM_CHAN   = 21;
    localparam int CHAN_W     = 5;
    localparam logic [4:0] CH_REMOTE1 = 5'h00;  // First converted channel.
    localparam logic [4:0] CH_GENERAL_ANALOG_EIGHT    = 5'h0E;  // Shared pair, analog view A.
    localparam logic [4:0] CH_GENERAL_ANALOG_NINE    = 5'h0F;  // Shared pair, analog view B.
    localparam logic [4:0] CH_BATTERY = 5'h12;  // Single unaveraged conversion.
    localparam logic [4:0] CH_REMOTE2 = 5'h13;  // Shared pair, diode view.
    localparam logic [4:0] CH_LOCAL   = 5'h14;  // Last converted channel.

    // ========================================================================
    // Register offsets and configuration fields.
    // ========================================================================
    localparam logic [7:0] CFG_ADDR      = 8'h00;
    localparam logic [7:0] LOCAL_ADDR    = 8'h1F;
    localparam logic [7:0] SHARED_A_ADDR = 8'h27;
    localparam logic [7:0] SHARED_B_ADDR = 8'h29;
    localparam logic [7:0] VALUE_BASE    = 8'h40;
    localparam logic [7:0] HIGH_BASE     = 8'h60;
    localparam logic [7:0] LOW_BASE      = 8'h80;
    localparam logic [7:0] ALARM_BASE    = 8'hA0;
    localparam int CFG_START_BIT  = 0;
    localparam int CFG_INTEN_BIT  = 1;
    localparam int CFG_INTCLR_BIT = 2;
    localparam int CFG_PAIR_BIT   = 3;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] HI_VOLT_RESET = 8'hFF;
    localparam logic [7:0] LO_VOLT_RESET = 8'h00;
    localparam logic [7:0] HI_TEMP_RESET = 8'h7F;
    localparam logic [7:0] LO_TEMP_RESET = 8'h80;
    localparam logic [7:0] INVALID_VALUE = 8'h00;

    // ========================================================================
    // Averaging and timing.
    // ========================================================================
    localparam int AVG_SAMPLES = 16;
    localparam int AVG_SHIFT   = 4;
    localparam int CORE_CLK_HZ = 250_000_000;
    localparam int ADC_CLK_HZ  = 22_500;
    localparam int TICK_DIV_CYCLES = CORE_CLK_HZ / ADC_CLK_HZ;
    localparam int SHORT_CONV_NS   = 711_000;
    localparam int LONG_CONV_NS    = 2_130_000;
    localparam int REMOTE_MEAS_NS  = 2_140_000;
    localparam int PASS_MAX_MS     = 290;
    localparam int SHORT_TICKS = int'((longint'(SHORT_CONV_NS) * ADC_CLK_HZ
                                       + 64'd999_999_999) / 64'd1_000_000_000);
    localparam int LONG_TICKS  = int'((longint'(LONG_CONV_NS) * ADC_CLK_HZ
                                       + 64'd999_999_999) / 64'd1_000_000_000);

    // ========================================================================
    // Types.
    // ========================================================================
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic       active;
        logic [4:0] chan;
        logic       long_conv;
    } conv_req_type;

    typedef enum logic [2:0] {
        SEQ_IDLE    = 3'b001,
        SEQ_CONVERT = 3'b010,
        SEQ_STORE   = 3'b100
    } seq_state_type;

endpackage

// ---- rtl/adc_tick_divider.sv ----
// ============================================================================
// Purpose: Divides the core clock down to the converter timebase enable.
// Assumes: Enable is a same-domain level.
// Notes:   Counter restarts whenever the enable drops.
// ============================================================================
`timescale 1ns/1ns
module adc_tick_divider
    import mon_pkg::*;
#(
    parameter int DIV_CYCLES = TICK_DIV_CYCLES
) (
    // Clock and reset.
    input  wire logic core_clk_i,
    input  wire logic resetn_i,
    // Control and enable.
    input  wire logic run_i,
    output logic      tick_o
);
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic        next_tick;

    // Counts core cycles and pulses once per timebase period.
    always_comb begin
        next_div_cnt = 16'h0000;
        next_tick    = 1'b0;
        if (run_i) begin
            if (div_cnt == 16'(DIV_CYCLES - 1)) begin
                next_tick = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 16'h0001;
            end
        end
    end

    // Registers the divider.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            div_cnt <= 16'h0000;
            tick_o  <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick_o  <= next_tick;
        end
    end
endmodule // adc_tick_divider

// ---- rtl/monitor_round_robin_sequencer.sv ----
// ============================================================================
// Purpose: Round-robin converter sequencer with averaging, limits and alarm.
// Assumes: Register requests come from serial-bus logic on the core clock.
// Notes:   Converter data comes from the analog side and is synchronised.
// ============================================================================
`timescale 1ns/1ns

module monitor_round_robin_sequencer
    import mon_pkg::*;
#(
    parameter int TICK_DIV = TICK_DIV_CYCLES
) (
    // Clock and reset.
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    // Register access from the serial management bus.
    input  wire reg_req_type  reg_req_i,
    output logic [7:0]        reg_rdata_o,
    // Converter.
    input  wire logic [7:0]   adc_data_i,
    output conv_req_type      conv_req_o,
    output logic              pair_is_analog_o,
    // Interrupt.
    output logic              int_o
);
    // ========================================================================
    // State.
    // ========================================================================
    seq_state_type state, next_state;
    logic [7:0]  cfg, next_cfg;
    logic [4:0]  chan, next_chan;
    logic [3:0]  sample_cnt, next_sample_cnt;
    logic [5:0]  tick_cnt, next_tick_cnt;
    logic [11:0] acc, next_acc;
    logic [7:0]  results [NUM_CHAN];
    logic [7:0]  next_results [NUM_CHAN];
    logic [7:0]  hi_lim [NUM_CHAN];
    logic [7:0]  next_hi_lim [NUM_CHAN];
    logic [7:0]  lo_lim [NUM_CHAN];
    logic [7:0]  next_lo_lim [NUM_CHAN];
    logic [NUM_CHAN-1:0] alarm, next_alarm;
    logic [7:0]  next_rdata;
    logic        next_int;
    conv_req_type next_conv;
    logic [7:0]  adc_meta, adc_sync;
    logic        tick, run, conv_end, store_ok;
    logic [7:0]  avg, shared_b_val;
    logic [5:0]  conv_ticks;

    // Channel attributes.
    function automatic logic is_temp(input logic [4:0] ch);
        return (ch == CH_REMOTE1) || (ch == CH_REMOTE2) || (ch == CH_LOCAL);
    endfunction
    function automatic logic is_long(input logic [4:0] ch);
        return (ch == CH_REMOTE1) || (ch == CH_REMOTE2);
    endfunction

    // ========================================================================
    // Timebase and converter data synchroniser.
    // ========================================================================
    assign run = cfg[CFG_START_BIT];

    // Converter timebase enable; fan speed timing lives outside this block.
    adc_tick_divider #(.DIV_CYCLES(TICK_DIV)) u_tick (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .run_i      (run),
        .tick_o     (tick)
    );

    // Two flops guard the analog-side data bus.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            adc_meta <= 8'h00;
            adc_sync <= 8'h00;
        end else begin
            adc_meta <= adc_data_i;
            adc_sync <= adc_meta;
        end
    end

    // ========================================================================
    // Sequencer.
    // ========================================================================
    assign conv_ticks = is_long(chan) ? 6'(LONG_TICKS) : 6'(SHORT_TICKS);
    assign conv_end   = (state == SEQ_CONVERT) && tick && (tick_cnt == conv_ticks - 6'h01);
    // Battery keeps its single raw sample; others take the truncated mean.
    assign avg = (chan == CH_BATTERY) ? acc[7:0] : acc[11:AVG_SHIFT];
    // The diode view of the pair is discarded while the pair is analog.
    assign store_ok = !((chan == CH_REMOTE2) && cfg[CFG_PAIR_BIT]);

    // Steps the channels and accumulates samples.
    always_comb begin
        next_state      = state;
        next_chan       = chan;
        next_sample_cnt = sample_cnt;
        next_tick_cnt   = tick_cnt;
        next_acc        = acc;
        case (state)
            SEQ_IDLE: begin
                if (run) begin
                    next_state      = SEQ_CONVERT;
                    next_chan       = CH_REMOTE1;
                    next_sample_cnt = 4'h0;
                    next_tick_cnt   = 6'h00;
                    next_acc        = 12'h000;
                end
            end
            SEQ_CONVERT: begin
                if (conv_end) begin
                    // Temperatures sum sign-extended, voltages zero-extended.
                    next_acc      = acc + {{4{is_temp(chan) & adc_sync[7]}}, adc_sync};
                    next_tick_cnt = 6'h00;
                    if (sample_cnt == 4'(AVG_SAMPLES - 1) || chan == CH_BATTERY) begin
                        next_state = SEQ_STORE;
                    end else begin
                        next_sample_cnt = sample_cnt + 4'h1;
                    end
                end else if (tick) begin
                    next_tick_cnt = tick_cnt + 6'h01;
                end
            end
            SEQ_STORE: begin
                // Every channel, both views of the pair included, each pass.
                next_state      = SEQ_CONVERT;
                next_chan       = (chan == CH_LOCAL) ? CH_REMOTE1 : chan + 5'h01;
                next_sample_cnt = 4'h0;
                next_acc        = 12'h000;
            end
            default: begin
                next_state = SEQ_IDLE;
            end
        endcase
        if (!run) begin
            next_state = SEQ_IDLE;
        end
    end

    // Registers the sequencer.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state      <= SEQ_IDLE;
            chan       <= 5'h00;
            sample_cnt <= 4'h0;
            tick_cnt   <= 6'h00;
            acc        <= 12'h000;
        end else begin
            state      <= next_state;
            chan       <= next_chan;
            sample_cnt <= next_sample_cnt;
            tick_cnt   <= next_tick_cnt;
            acc        <= next_acc;
        end
    end

    // ========================================================================
    // Results, limits, alarms and register access.
    // ========================================================================
    assign shared_b_val = cfg[CFG_PAIR_BIT] ? results[CH_GENERAL_ANALOG_NINE] : results[CH_REMOTE2];

    // Stores results, compares limits and serves register accesses.
    always_comb begin
        next_cfg     = cfg;
        next_results = results;
        next_hi_lim  = hi_lim;
        next_lo_lim  = lo_lim;
        next_alarm   = alarm;
        next_rdata   = reg_rdata_o;
        // Software writes; limits sit at a base plus channel index.
        if (reg_req_i.wr) begin
            if (reg_req_i.addr == CFG_ADDR) begin
                next_cfg = reg_req_i.wdata;
            end else if (reg_req_i.addr >= HIGH_BASE && reg_req_i.addr < HIGH_BASE + 8'(NUM_CHAN)) begin
                next_hi_lim[5'(reg_req_i.addr - HIGH_BASE)] = reg_req_i.wdata;
            end else if (reg_req_i.addr >= LOW_BASE && reg_req_i.addr < LOW_BASE + 8'(NUM_CHAN)) begin
                next_lo_lim[5'(reg_req_i.addr - LOW_BASE)] = reg_req_i.wdata;
            end
        end
        // Clearing acknowledges voltage alarms; a new event below still wins.
        if (cfg[CFG_INTCLR_BIT]) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (!is_temp(5'(i))) begin
                    next_alarm[i] = 1'b0;
                end
            end
        end
        if (state == SEQ_STORE && store_ok) begin
            next_results[chan] = avg;
            if (is_temp(chan)) begin
                if ($signed(avg) > $signed(hi_lim[chan])) begin
                    next_alarm[chan] = 1'b1;
                end else if ($signed(avg) <= $signed(lo_lim[chan])) begin
                    next_alarm[chan] = 1'b0;
                end
            end else if (avg > hi_lim[chan] || avg < lo_lim[chan]) begin
                next_alarm[chan] = 1'b1;
            end
        end
        // Reads; unmapped offsets return zero.
        if (reg_req_i.rd) begin
            if (reg_req_i.addr == CFG_ADDR) begin
                next_rdata = cfg;
            end else if (reg_req_i.addr == LOCAL_ADDR) begin
                next_rdata = results[CH_LOCAL];
            end else if (reg_req_i.addr == SHARED_A_ADDR) begin
                next_rdata = cfg[CFG_PAIR_BIT] ? results[CH_GENERAL_ANALOG_EIGHT] : INVALID_VALUE;
            end else if (reg_req_i.addr == SHARED_B_ADDR) begin
                next_rdata = shared_b_val;
            end else if (reg_req_i.addr >= VALUE_BASE && reg_req_i.addr < VALUE_BASE + 8'(NUM_CHAN)) begin
                next_rdata = results[5'(reg_req_i.addr - VALUE_BASE)];
            end else if (reg_req_i.addr >= HIGH_BASE && reg_req_i.addr < HIGH_BASE + 8'(NUM_CHAN)) begin
                next_rdata = hi_lim[5'(reg_req_i.addr - HIGH_BASE)];
            end else if (reg_req_i.addr >= LOW_BASE && reg_req_i.addr < LOW_BASE + 8'(NUM_CHAN)) begin
                next_rdata = lo_lim[5'(reg_req_i.addr - LOW_BASE)];
            end else if (reg_req_i.addr >= ALARM_BASE && reg_req_i.addr < ALARM_BASE + 8'h03) begin
                next_rdata = 8'(32'({3'h0, alarm}) >> (8 * (reg_req_i.addr - ALARM_BASE)));
            end else begin
                next_rdata = 8'h00;
            end
        end
        next_int  = cfg[CFG_INTEN_BIT] && !cfg[CFG_INTCLR_BIT] && (|alarm);
        next_conv = '{active: (state == SEQ_CONVERT), chan: chan, long_conv: is_long(chan)};
    end

    // Registers results, limits, alarms and outputs.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cfg              <= CFG_RESET;
            alarm            <= '0;
            reg_rdata_o      <= 8'h00;
            int_o            <= 1'b0;
            conv_req_o       <= '0;
            pair_is_analog_o <= 1'b0;
            for (int i = 0; i < NUM_CHAN; i++) begin
                results[i] <= 8'h00;
                hi_lim[i]  <= is_temp(5'(i)) ? HI_TEMP_RESET : HI_VOLT_RESET;
                lo_lim[i]  <= is_temp(5'(i)) ? LO_TEMP_RESET : LO_VOLT_RESET;
            end
        end else begin
            cfg              <= next_cfg;
            alarm            <= next_alarm;
            reg_rdata_o      <= next_rdata;
            int_o            <= next_int;
            conv_req_o       <= next_conv;
            pair_is_analog_o <= cfg[CFG_PAIR_BIT];
            results          <= next_results;
            hi_lim           <= next_hi_lim;
            lo_lim           <= next_lo_lim;
        end
    end

    // ========================================================================
    // Assertions.
    // ========================================================================
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    a_int_gate: assert property (!cfg[CFG_INTEN_BIT] |=> !int_o)
        else $error("Interrupt driven while disabled.");
    a_start_first: assert property (state == SEQ_IDLE && run |=>
        state == SEQ_CONVERT && chan == CH_REMOTE1)
        else $error("Pass did not start on remote channel one.");
    a_stop_idle: assert property (!run |=> state == SEQ_IDLE)
        else $error("Sequencer kept running after stop.");
    a_wrap_local: assert property (state == SEQ_STORE && chan == CH_LOCAL && run |=>
        chan == CH_REMOTE1)
        else $error("Pass did not wrap after local temperature.");
    a_store_value: assert property (state == SEQ_STORE && store_ok |=>
        results[$past(chan)] == $past(avg))
        else $error("Result not stored.");
    a_tick_bound: assert property (state == SEQ_CONVERT |-> tick_cnt < conv_ticks)
        else $error("Conversion ran past its length.");
    a_discard_temp: assert property (state == SEQ_STORE && chan == CH_REMOTE2 &&
        cfg[CFG_PAIR_BIT] |=> $stable(results[CH_REMOTE2]))
        else $error("Discarded temperature was stored.");
    a_shared_read: assert property (reg_req_i.rd && reg_req_i.addr == SHARED_B_ADDR &&
        !reg_req_i.wr |=> reg_rdata_o == $past(shared_b_val))
        else $error("Shared register read wrong value.");
    a_sample_count: assert property (state == SEQ_STORE && chan != CH_BATTERY |->
        sample_cnt == 4'(AVG_SAMPLES - 1))
        else $error("Average formed from wrong sample count.");
    c_full_pass: cover property (state == SEQ_STORE && chan == CH_LOCAL);
    c_alarm_int: cover property (int_o);
    c_battery: cover property (state == SEQ_STORE && chan == CH_BATTERY);
endmodule // monitor_round_robin_sequencer

// ---- bench/analog_front_model.sv ----
// ========================================
// Purpose: Analog side model that answers every conversion request.
// Assumes: The byte is held steady for the whole of one channel.
// Notes:   Between channels the line shows the inverse of its last value.
// ========================================
`timescale 1ns/1ns
module analog_front_model
    import mon_pkg::*;
(
    // Clock and pass salt.
    input  wire logic         core_clk_i,
    input  wire logic [7:0]   salt_i,
    // Converter request and data.
    input  wire conv_req_type conv_req_i,
    output logic [7:0]        adc_data_o
);
    // Start from a known byte so the synchroniser never sees an unknown.
    initial adc_data_o = 8'h5A;
    // Each channel reads back its own byte; temperature bytes may be negative.
    always @(posedge core_clk_i) begin
        if (conv_req_i.active) begin
            adc_data_o <= 8'(conv_req_i.chan * 7) + salt_i;
        end else begin
            adc_data_o <= ~adc_data_o;
        end
    end
endmodule // analog_front_model

// ---- bench/tb_monitor_round_robin_sequencer.sv ----
// ========================================
// Purpose: Self-checking bench for the round-robin sequencer.
// Assumes: Tick divider shortened to 4 core cycles.
// Notes:   Two passes, one per pair mode, with alarm and stop checks.
// ========================================
`timescale 1ns/1ns
module tb_monitor_round_robin_sequencer;
    import mon_pkg::*;
    // Divider length used in place of the real timebase.
    localparam int TB_DIV = 4;
    logic         core_clk_i = 1'b0;
    logic         resetn_i   = 1'b0;
    reg_req_type  reg_req_i  = '0;
    logic [7:0]   reg_rdata_o, adc_data_i, salt, rv, prev_salt;
    conv_req_type conv_req_o;
    logic         pair_is_analog_o, int_o;
    int           n_fail = 0, checks = 0, cyc = 0, seed = 8726, last_ch = 20;
    int           span = 0, n_chg = 0;

    // Design and analog side.
    monitor_round_robin_sequencer #(.TICK_DIV(TB_DIV)) dut (.core_clk_i(core_clk_i),
        .resetn_i(resetn_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
        .adc_data_i(adc_data_i), .conv_req_o(conv_req_o),
        .pair_is_analog_o(pair_is_analog_o), .int_o(int_o));
    analog_front_model model (.core_clk_i(core_clk_i), .salt_i(salt),
        .conv_req_i(conv_req_o), .adc_data_o(adc_data_i));

    // Clock and hang guard.
    initial forever #2 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            results();
        end
    end

    // Expected byte of a channel in the current pass.
    function automatic logic [7:0] val(input int ch);
        return 8'(ch * 7) + salt;
    endfunction

    // Core cycles one channel lasts: conversions times ticks times the divider.
    function automatic int span_of(input int ch);
        int n;
        n = (ch == 0 || ch == 19) ? LONG_TICKS : SHORT_TICKS;
        return TB_DIV * n * ((ch == 18) ? 1 : AVG_SAMPLES);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i) reg_req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk_i) reg_req_i = '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_i) reg_req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge core_clk_i) reg_req_i = '0;
        d = reg_rdata_o;
    endtask

    // Waits until the local channel of a pass has been stored.
    task automatic wait_pass();
        int n;
        for (n = 0; n < 40000 && !(conv_req_o.active === 1'b1 && conv_req_o.chan == 20); n++)
            @(negedge core_clk_i);
        for (n = 0; n < 2000 && conv_req_o.active === 1'b1; n++) @(negedge core_clk_i);
        repeat (3) @(negedge core_clk_i);
    endtask

    // Channel order, conversion kind and channel length seen at each change.
    // The first channel after a start is not aligned to the timebase, so
    // lengths are only compared from the third change on.
    always @(negedge core_clk_i) begin
        span++;
        if (resetn_i && conv_req_o.active === 1'b1 && conv_req_o.chan != last_ch) begin
            check(8'(conv_req_o.chan), (last_ch == 20) ? 8'h00 : 8'(last_ch + 1));
            check({7'h00, conv_req_o.long_conv},
                  {7'h00, conv_req_o.chan == 0 || conv_req_o.chan == 19});
            if (n_chg >= 2) begin
                check(8'(span >> 8), 8'(span_of(last_ch) >> 8));
                check(8'(span), 8'(span_of(last_ch)));
            end
            n_chg++;
            span = 0;
            last_ch = conv_req_o.chan;
        end
    end

    // Main sequence: reset, two passes, alarm, interrupt and stop.
    initial begin
        salt = (8'($random(seed)) & 8'h3F) | 8'h01;
        repeat (12) @(negedge core_clk_i);
        resetn_i = 1'b1;
        rd(CFG_ADDR, rv);
        check(rv, 8'h00);
        check({7'h00, int_o}, 8'h00);
        wr(HIGH_BASE + 8'h01, 8'h00);
        wr(HIGH_BASE, 8'h00);
        wr(CFG_ADDR, 8'h01);
        wait_pass();
        for (int ch = 0; ch < 21; ch++) begin
            rd(VALUE_BASE + 8'(ch), rv);
            check(rv, val(ch));
        end
        rd(LOCAL_ADDR, rv);
        check(rv, val(20));
        rd(SHARED_B_ADDR, rv);
        check(rv, val(19));
        rd(SHARED_A_ADDR, rv);
        check(rv, INVALID_VALUE);
        rd(8'hF0, rv);
        check(rv, 8'h00);
        wr(LOCAL_ADDR, 8'hC3);
        rd(LOCAL_ADDR, rv);
        check(rv, val(20));
        rd(ALARM_BASE, rv);
        check(rv, 8'h03);
        check({7'h00, int_o}, 8'h00);
        wr(CFG_ADDR, 8'h03);
        repeat (3) @(negedge core_clk_i);
        check({7'h00, int_o}, 8'h01);
        wr(CFG_ADDR, 8'h07);
        repeat (3) @(negedge core_clk_i);
        check({7'h00, int_o}, 8'h00);
        wr(CFG_ADDR, 8'h00);
        repeat (3) @(negedge core_clk_i);
        check({7'h00, conv_req_o.active}, 8'h00);
        repeat (300) @(negedge core_clk_i);
        check({7'h00, conv_req_o.active}, 8'h00);
        last_ch = 20;
        n_chg = 0;
        prev_salt = salt;
        salt = (8'($random(seed)) & 8'h3F) | 8'h01;
        wr(CFG_ADDR, 8'h0B);
        // Hot limit back up, hysteresis above every byte: channel zero releases.
        wr(HIGH_BASE, 8'h7F);
        wr(LOW_BASE, 8'h40);
        repeat (3) @(negedge core_clk_i);
        check({7'h00, pair_is_analog_o}, 8'h01);
        wait_pass();
        rd(SHARED_A_ADDR, rv);
        check(rv, val(14));
        rd(SHARED_B_ADDR, rv);
        check(rv, val(15));
        // The diode view keeps the byte of the earlier pass while discarded.
        for (int ch = 0; ch < 21; ch++) begin
            rd(VALUE_BASE + 8'(ch), rv);
            check(rv, (ch == 19) ? 8'(19 * 7) + prev_salt : val(ch));
        end
        rd(LOW_BASE, rv);
        check(rv, 8'h40);
        rd(ALARM_BASE, rv);
        check(rv, 8'h02);
        check({7'h00, int_o}, 8'h01);
        // A reset in mid-run brings back the reset state and stops the pass.
        resetn_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        resetn_i = 1'b1;
        rd(CFG_ADDR, rv);
        check(rv, CFG_RESET);
        rd(HIGH_BASE + 8'h01, rv);
        check(rv, HI_VOLT_RESET);
        rd(LOW_BASE, rv);
        check(rv, LO_TEMP_RESET);
        rd(VALUE_BASE, rv);
        check(rv, 8'h00);
        check({7'h00, conv_req_o.active}, 8'h00);
        check({7'h00, pair_is_analog_o}, 8'h00);
        check({7'h00, int_o}, 8'h00);
        wr(CFG_ADDR, 8'h00);
        results();
    end
endmodule // tb_monitor_round_robin_sequencer
